// file: shared/status_loop_map.svh
/*
 Register offsets, field positions, reset values and timing counts of the
 indicator and local loop block. Assumes a 125 MHz core clock.
*/
`ifndef STATUS_LOOP_MAP_SVH
`define STATUS_LOOP_MAP_SVH
// Notes on behaviour
// - TD and RD indicators red on idle or one, green on zero.
// - Clear-to-send indicator green whenever clear-to-send is asserted.
// - Carrier indicator green only while a valid carrier is detected.
// - Terminal-ready indicator green while the terminal holds DTR active.
// - No-signal indicator red whenever the line receiver sees no signal.
// - Out-of-service indicator red whenever the network sends out-of-service.
// - Error indicator flashes on bipolar violations or framing errors.
// - During a 511 test the error indicator flashes per checker bit error.
// - Test-mode indicator red whenever any test mode is active.
// - Keep a received error count, cleared to zero on each read.
// - In local loopback terminal transmit data returns on the receive path.
// - Enter local loopback while the panel loop switch is in local.
// - Enter local loopback on the terminal local-loop lead when enabled.
// - Enter local loopback when the software loop setting is one.
// - Terminal loop control defaults disabled; then both loop leads ignored.

// Byte offsets on the register bus.
`define CTRL_OFF         8'h00
`define IRQ_STAT_OFF     8'h04
`define IRQ_MASK_OFF     8'h08
`define ERR_COUNT_OFF    8'h0C
`define LIVE_OFF         8'h10
// Control fields and their reset values.
`define CTRL_TERM_EN_BIT 0
`define CTRL_SW_LOOP_BIT 1
`define CTRL_RESET       2'h0
`define SW_LOOP_ACTIVE   1'h1
// Interrupt status bit positions.
`define EV_LINE_BIT      0
`define EV_PATTERN_BIT   1
`define EV_NO_SIG_BIT    2
`define EV_OOS_BIT       3
`define IRQ_RESET        4'h0
// Error flash length and error count limit.
`define CLK_MHZ          125
`define STRETCH_MS       50
`define ERR_COUNT_MAX    16'hFFFF
`endif

// file: shared/status_loop_pkg.sv
/*
 Types of the indicator and local loop block. Assumes the map header is
 compiled alongside.
*/
package status_loop_pkg;
   // Front panel lamp drives, one bit per lamp colour.
   typedef struct packed {
      logic td_red;
      logic td_green;
      logic rd_red;
      logic rd_green;
      logic cts_green;
      logic cd_green;
      logic dtr_green;
      logic ns_red;
      logic os_red;
      logic err_red;
      logic tm_red;
   } panel_leds_s;

   typedef logic [2:0] reg_idx_t;

   // Whole state of the block.
   typedef struct packed {
      panel_leds_s leds;
      logic        rxd_term;
      logic        txd_line;
      logic        local_analog_loopback;
      logic        rl_req;
      logic        term_en;
      logic        sw_loop;
      logic [3:0]  irq_stat;
      logic [3:0]  irq_mask;
      logic        irq;
      logic [15:0] err_cnt;
      logic [22:0] stretch;
      logic        ns_prev;
      logic        os_prev;
      logic        ph_act;
      logic        ph_wr;
      logic        ph_ok;
      reg_idx_t    ph_idx;
      logic [31:0] rdata;
      logic        ready;
   } state_s;
endpackage

// file: rtl/status_loop.sv
/*
 Front panel indicator logic, received error counter and local analog
 loopback selection, with an AHB-Lite register slave and one interrupt.
 Assumes all inputs are synchronous to ref_clk_in and that the line
 receiver and pattern checker deliver error events as one-cycle pulses.
*/
`include "status_loop_map.svh"

module status_loop
   import status_loop_pkg::*;
#(
   parameter int STRETCH_CYCLES = `STRETCH_MS * `CLK_MHZ * 1000
)(
   input  wire logic        ref_clk_in,
   input  wire logic        resetn_in,
   // AHB-Lite slave.
   input  wire logic        hsel_in,
   input  wire logic [31:0] haddr_in,
   input  wire logic [1:0]  htrans_in,
   input  wire logic        hwrite_in,
   input  wire logic [2:0]  hsize_in,
   input  wire logic        hready_in,
   input  wire logic [31:0] hwdata_in,
   output logic      [31:0] hrdata_out,
   output logic             hreadyout_out,
   output logic             hresp_out,
   output logic             irq_out,
   // Terminal side.
   input  wire logic        txd_in,
   input  wire logic        cts_in,
   input  wire logic        dtr_in,
   input  wire logic        terminal_local_loop_lead_in,
   input  wire logic        terminal_remote_loop_lead_in,
   output logic             rxd_term_out,
   // Line side.
   input  wire logic        rxd_line_in,
   input  wire logic        carrier_in,
   input  wire logic        no_line_signal_in,
   input  wire logic        out_of_service_in,
   input  wire logic        bipolar_violation_in,
   input  wire logic        framing_error_in,
   output logic             txd_line_out,
   // Pattern checker and other tests.
   input  wire logic        pattern_test_in,
   input  wire logic        pattern_error_in,
   input  wire logic        other_test_in,
   // Front panel.
   input  wire logic        panel_loop_local_in,
   output panel_leds_s      leds_out,
   output logic             local_analog_loopback_out,
   output logic             terminal_remote_loop_req_out
);

   localparam logic [22:0] STRETCH_LEN = 23'(STRETCH_CYCLES);

   state_s st_q;
   state_s st_d;
   logic   ev_line;
   logic   ev_pat;
   logic   ev_err;
   logic   rd_now;
   logic [3:0] ev_vec;

   // Maps a byte address to a register index; used on both bus phases.
   function automatic reg_idx_t reg_index(input logic [31:0] addr);
      reg_index = addr[4:2];
   endfunction

   // An address is mapped when it hits one of the five words.
   function automatic logic reg_mapped(input logic [31:0] addr);
      reg_mapped = (addr[31:5] == 27'h0) && (addr[4:2] <= reg_index(32'(`LIVE_OFF)));
   endfunction

   // Next state. Writes are applied before reads are served so that a read
   // right behind a write sees the new value.
   always_comb begin
      st_d    = st_q;
      ev_line = bipolar_violation_in | framing_error_in;
      ev_pat  = pattern_test_in & pattern_error_in;
      ev_err  = ev_line | ev_pat;
      ev_vec  = '0;
      ev_vec[`EV_LINE_BIT]    = ev_line;
      ev_vec[`EV_PATTERN_BIT] = ev_pat;
      ev_vec[`EV_NO_SIG_BIT]  = no_line_signal_in & ~st_q.ns_prev;
      ev_vec[`EV_OOS_BIT]     = out_of_service_in & ~st_q.os_prev;
      st_d.ns_prev = no_line_signal_in;
      st_d.os_prev = out_of_service_in;
      st_d.ready   = 1'h1;

      // Data phase of a write.
      if (st_q.ph_act && st_q.ph_wr && st_q.ph_ok) begin
         unique case (st_q.ph_idx)
            reg_index(32'(`CTRL_OFF)): begin
               st_d.term_en = hwdata_in[`CTRL_TERM_EN_BIT];
               st_d.sw_loop = hwdata_in[`CTRL_SW_LOOP_BIT];
            end
            reg_index(32'(`IRQ_MASK_OFF)): begin
               st_d.irq_mask = hwdata_in[3:0];
            end
            default: begin
            end
         endcase
      end

      // Address phase: capture and load read data for the data phase.
      st_d.ph_act = hsel_in & htrans_in[1] & hready_in;
      st_d.ph_wr  = hwrite_in;
      st_d.ph_ok  = reg_mapped(haddr_in);
      st_d.ph_idx = reg_index(haddr_in);
      rd_now      = st_d.ph_act & ~hwrite_in & st_d.ph_ok;
      st_d.rdata  = '0;
      if (rd_now) begin
         unique case (st_d.ph_idx)
            reg_index(32'(`CTRL_OFF)): begin
               st_d.rdata[`CTRL_TERM_EN_BIT] = st_d.term_en;
               st_d.rdata[`CTRL_SW_LOOP_BIT] = st_d.sw_loop;
            end
            reg_index(32'(`IRQ_STAT_OFF)):  st_d.rdata[3:0]  = st_q.irq_stat;
            reg_index(32'(`IRQ_MASK_OFF)):  st_d.rdata[3:0]  = st_d.irq_mask;
            reg_index(32'(`ERR_COUNT_OFF)): st_d.rdata[15:0] = st_q.err_cnt;
            default: begin
               st_d.rdata[10:0] = st_q.leds;
               st_d.rdata[11]   = st_q.local_analog_loopback;
               st_d.rdata[12]   = st_q.rl_req;
            end
         endcase
      end

      // Sticky events: a read clears, but an event in the same cycle wins.
      if (rd_now && st_d.ph_idx == reg_index(32'(`IRQ_STAT_OFF))) begin
         st_d.irq_stat = '0;
      end
      st_d.irq_stat = st_d.irq_stat | ev_vec;
      st_d.irq      = |(st_d.irq_stat & st_d.irq_mask);

      // Error count clears on read; an error in the read cycle counts one.
      if (rd_now && st_d.ph_idx == reg_index(32'(`ERR_COUNT_OFF))) begin
         st_d.err_cnt = '0;
      end
      if (ev_err && st_d.err_cnt != `ERR_COUNT_MAX) begin
         st_d.err_cnt = st_d.err_cnt + 16'h0001;
      end

      // Flash stretcher: a short event would be invisible on a lamp.
      if (ev_err) begin
         st_d.stretch = STRETCH_LEN;
      end else if (st_q.stretch != '0) begin
         st_d.stretch = st_q.stretch - 23'h000001;
      end

      // Loopback selection; the leads count only with terminal control on.
      st_d.local_analog_loopback = panel_loop_local_in
               | (st_q.term_en & terminal_local_loop_lead_in)
               | (st_q.sw_loop == `SW_LOOP_ACTIVE);
      st_d.rl_req   = st_q.term_en & terminal_remote_loop_lead_in;
      st_d.rxd_term = st_d.local_analog_loopback ? txd_in : rxd_line_in;
      st_d.txd_line = txd_in;

      // Lamps. Idle lines sit at one, so idle shows red like a one.
      st_d.leds.td_red    = txd_in;
      st_d.leds.td_green  = ~txd_in;
      st_d.leds.rd_red    = st_d.rxd_term;
      st_d.leds.rd_green  = ~st_d.rxd_term;
      st_d.leds.cts_green = cts_in;
      st_d.leds.cd_green  = carrier_in;
      st_d.leds.dtr_green = dtr_in;
      st_d.leds.ns_red    = no_line_signal_in;
      st_d.leds.os_red    = out_of_service_in;
      st_d.leds.err_red   = (st_d.stretch != '0);
      st_d.leds.tm_red    = st_d.local_analog_loopback | pattern_test_in | other_test_in;
   end

   // State register with synchronous reset.
   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         st_q          <= '0;
         st_q.term_en  <= 1'(`CTRL_RESET >> `CTRL_TERM_EN_BIT);
         st_q.irq_stat <= `IRQ_RESET;
         st_q.irq_mask <= `IRQ_RESET;
         st_q.ready    <= 1'h1;
         st_q.rxd_term <= 1'h1;
         st_q.txd_line <= 1'h1;
      end else begin
         st_q <= st_d;
      end
   end

   // All outputs except hresp_out, which is tied low, come straight from the state register.
   assign hrdata_out                   = st_q.rdata;
   assign hreadyout_out                = st_q.ready;
   assign hresp_out                    = 1'h0;
   assign irq_out                      = st_q.irq;
   assign rxd_term_out                 = st_q.rxd_term;
   assign txd_line_out                 = st_q.txd_line;
   assign leds_out                     = st_q.leds;
   assign local_analog_loopback_out    = st_q.local_analog_loopback;
   assign terminal_remote_loop_req_out = st_q.rl_req;

   // Checks on the lamp, counter and loop logic.
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!resetn_in);

   a_td_colour: assert property (
      $past(resetn_in) |-> (leds_out.td_red == $past(txd_in)) && (leds_out.td_green != leds_out.td_red))
      else $error("TD lamp colour does not follow transmit data.");

   a_rd_colour: assert property (
      $past(resetn_in) |-> leds_out.rd_red == rxd_term_out && leds_out.rd_green == !rxd_term_out)
      else $error("RD lamp colour does not follow receive data.");

   a_cts_lamp: assert property (
      $past(resetn_in) |-> leds_out.cts_green == $past(cts_in))
      else $error("CTS lamp does not follow clear-to-send.");

   a_cd_lamp: assert property (
      $past(resetn_in) && !$past(carrier_in) |-> !leds_out.cd_green)
      else $error("Carrier lamp lit without carrier.");

   a_dtr_lamp: assert property (
      $rose(dtr_in) |=> leds_out.dtr_green)
      else $error("DTR lamp late.");

   a_ns_os_lamps: assert property (
      $past(resetn_in) |-> leds_out.ns_red == $past(no_line_signal_in) && leds_out.os_red == $past(out_of_service_in))
      else $error("Line condition lamps wrong.");

   a_err_flash: assert property (
      (bipolar_violation_in || framing_error_in) |=> leds_out.err_red [*8])
      else $error("Line error flash too short.");

   a_pattern_flash: assert property (
      (pattern_test_in && pattern_error_in) |=> leds_out.err_red && st_q.irq_stat[`EV_PATTERN_BIT])
      else $error("Pattern error not shown.");

   a_test_lamp: assert property (
      local_analog_loopback_out |-> leds_out.tm_red)
      else $error("Test lamp dark during loopback.");

   a_count_clear: assert property (
      (hsel_in && htrans_in[1] && hready_in && !hwrite_in && haddr_in == 32'(`ERR_COUNT_OFF) && !ev_err)
      |=> st_q.err_cnt == 16'h0000 && hrdata_out[15:0] == $past(st_q.err_cnt))
      else $error("Error count not cleared by read.");

   a_loop_echo: assert property (
      $past(resetn_in) && local_analog_loopback_out |-> rxd_term_out == $past(txd_in))
      else $error("Loopback does not echo transmit data.");

   a_loop_select: assert property (
      $past(resetn_in) |-> local_analog_loopback_out == $past(panel_loop_local_in
         || (st_q.term_en && terminal_local_loop_lead_in) || st_q.sw_loop))
      else $error("Loopback source selection wrong.");

   a_leads_ignored: assert property (
      !st_q.term_en && !panel_loop_local_in && !st_q.sw_loop |=> !local_analog_loopback_out && !terminal_remote_loop_req_out)
      else $error("Loop lead obeyed while terminal control is off.");

   c_loop_lead: cover property (st_q.term_en && terminal_local_loop_lead_in ##1 local_analog_loopback_out);
   c_count_read: cover property (ev_err ##[1:20] (st_q.ph_act && st_q.ph_idx == 3'h3));
   c_irq_raise: cover property ($rose(irq_out));
   c_flash_restart: cover property (ev_err ##[1:6] ev_err);

endmodule

// file: bench/dte_line_model.sv
/*
 Far-side model: the terminal's data and leads and the line receiver.
 Assumes the bench calls its tasks from one sequence; every change
 follows a rising edge of clk_in.
*/
module dte_line_model (
   input  wire logic clk_in,
   output logic      txd_out,
   output logic      rxd_out,
   output logic      cts_out,
   output logic      dtr_out,
   output logic      cd_out,
   output logic      ns_out,
   output logic      os_out,
   output logic      ll_out,
   output logic      rl_out,
   output logic      bpv_out,
   output logic      fe_out,
   output logic      pe_out
);
   timeunit 1ns;
   timeprecision 1ps;

   // Terminal data idles at one, leads start released, no events pending.
   initial begin
      {txd_out, rxd_out, cts_out, dtr_out, cd_out, ns_out, os_out} = 7'h7C;
      {ll_out, rl_out, bpv_out, fe_out, pe_out} = 5'h00;
   end

   // Levels in the order txd, rxd, cts, dtr, carrier, no-signal, out-of-service.
   task automatic drive(input logic [6:0] v);
      @(posedge clk_in);
      {txd_out, rxd_out, cts_out, dtr_out, cd_out, ns_out, os_out} <= v;
   endtask

   // Terminal loop leads in the order local, remote; raised to ask for a test.
   task automatic leads(input logic [1:0] v);
      @(posedge clk_in);
      {ll_out, rl_out} <= v;
   endtask

   // One-cycle error event: 0 bipolar, 1 framing, 2 pattern checker.
   task automatic pulse(input int k);
      @(posedge clk_in);
      bpv_out <= (k == 0);
      fe_out  <= (k == 1);
      pe_out  <= (k == 2);
      @(posedge clk_in);
      {bpv_out, fe_out, pe_out} <= 3'h0;
   endtask
endmodule

// file: bench/status_loop_tb_top.sv
/*
 Self-checking bench of the indicator and local loop block.
 Assumes the far-side model and an error stretch shortened to 16 cycles.
*/
`include "status_loop_map.svh"

module status_loop_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import status_loop_pkg::*;

   logic        ref_clk_in;
   logic        resetn_in;
   logic        hsel_in;
   logic        hwrite_in;
   logic [1:0]  htrans_in;
   logic [2:0]  hsize_in;
   logic [31:0] haddr_in;
   logic [31:0] hwdata_in;
   logic [31:0] hrdata_out, rd;
   logic        hreadyout_out, hresp_out, irq_out, rxd_term_out, txd_line_out;
   logic        txd_in, cts_in, dtr_in, ll_in, rl_in, rxd_line_in, carrier_in;
   logic        ns_in, os_in, bpv_in, fe_in, pe_in;
   logic        pattern_test_in;
   logic        other_test_in;
   logic        panel_in;
   logic        lal_out, rl_req_out;
   panel_leds_s leds_out;
   int          errors = 0;
   int          checked = 0;
   int          cycles = 0;

   status_loop #(.STRETCH_CYCLES(16)) dut_u (
      .ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
      .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(hsize_in), .hready_in(hreadyout_out),
      .hwdata_in(hwdata_in), .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
      .hresp_out(hresp_out), .irq_out(irq_out), .txd_in(txd_in), .cts_in(cts_in), .dtr_in(dtr_in),
      .terminal_local_loop_lead_in(ll_in), .terminal_remote_loop_lead_in(rl_in),
      .rxd_term_out(rxd_term_out), .rxd_line_in(rxd_line_in), .carrier_in(carrier_in),
      .no_line_signal_in(ns_in), .out_of_service_in(os_in), .bipolar_violation_in(bpv_in),
      .framing_error_in(fe_in), .txd_line_out(txd_line_out), .pattern_test_in(pattern_test_in),
      .pattern_error_in(pe_in), .other_test_in(other_test_in), .panel_loop_local_in(panel_in),
      .leds_out(leds_out), .local_analog_loopback_out(lal_out), .terminal_remote_loop_req_out(rl_req_out));

   dte_line_model far_u (
      .clk_in(ref_clk_in), .txd_out(txd_in), .rxd_out(rxd_line_in), .cts_out(cts_in), .dtr_out(dtr_in),
      .cd_out(carrier_in), .ns_out(ns_in), .os_out(os_in), .ll_out(ll_in), .rl_out(rl_in),
      .bpv_out(bpv_in), .fe_out(fe_in), .pe_out(pe_in));

   // Free-running 125 MHz clock.
   initial begin
      forever #4 ref_clk_in = ~ref_clk_in;
   end

   // Cuts a hang short; the whole run needs well under 1000 cycles.
   always @(posedge ref_clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         errors++;
         end_of_test();
      end
   end

   task automatic step(input int n);
      repeat (n) @(posedge ref_clk_in);
   endtask

   // Counts every comparison and reports a difference at once.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   // One single AHB-Lite transfer; waits on hready, read data taken at the closing edge.
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
      @(posedge ref_clk_in);
      hsel_in <= 1'h1;
      haddr_in <= {24'h0, a};
      hwrite_in <= w;
      htrans_in <= 2'h2;
      do @(posedge ref_clk_in); while (hreadyout_out !== 1'h1);
      htrans_in <= 2'h0;
      hwdata_in <= wd;
      do @(posedge ref_clk_in); while (hreadyout_out !== 1'h1);
      r = hrdata_out;
      check(hresp_out, 1'h0);
   endtask

   // Each line and lead lamp follows its signal, with both polarities of every input.
   task automatic t_lamps;
      far_u.drive(7'h35);
      step(3);
      check(leds_out, 11'h364);
      far_u.drive(7'h4A);
      step(3);
      check(leds_out, 11'h498);
      far_u.drive(7'h7C);
      $display("lamps done");
   endtask

   // Two line errors: flash, restart of the stretch, interrupt and read-clear count.
   task automatic t_errors;
      xfer(1'h1, `IRQ_MASK_OFF, 32'h1, rd);
      xfer(1'h0, `IRQ_STAT_OFF, 32'h0, rd);
      far_u.pulse(0);
      step(1);
      check(leds_out.err_red, 1'h1);
      step(12);
      far_u.pulse(1);
      step(10);
      check(leds_out.err_red, 1'h1);
      step(10);
      check(leds_out.err_red, 1'h0);
      check(irq_out, 1'h1);
      xfer(1'h0, `IRQ_STAT_OFF, 32'h0, rd);
      check(rd, 32'h1);
      step(2);
      check(irq_out, 1'h0);
      xfer(1'h0, `ERR_COUNT_OFF, 32'h0, rd);
      check(rd, 32'h2);
      xfer(1'h0, `ERR_COUNT_OFF, 32'h0, rd);
      check(rd, 32'h0);
      $display("errors done");
   endtask

   // Pattern test: test lamp, flash per checker error, masked status bit.
   task automatic t_pattern;
      @(posedge ref_clk_in);
      pattern_test_in <= 1'h1;
      far_u.pulse(2);
      step(1);
      check(leds_out.err_red, 1'h1);
      check(leds_out.tm_red, 1'h1);
      check(irq_out, 1'h0);
      xfer(1'h0, `IRQ_STAT_OFF, 32'h0, rd);
      check(rd, 32'h2);
      xfer(1'h0, `ERR_COUNT_OFF, 32'h0, rd);
      check(rd, 32'h1);
      pattern_test_in <= 1'h0;
      other_test_in <= 1'h1;
      step(3);
      check(leds_out.tm_red, 1'h1);
      other_test_in <= 1'h0;
      step(3);
      check(leds_out.tm_red, 1'h0);
      $display("pattern done");
   endtask

   // Loop sources one by one, the disabled leads, and the unmapped address.
   task automatic t_loop;
      @(posedge ref_clk_in);
      panel_in <= 1'h1;
      far_u.drive(7'h3C);
      step(3);
      check({lal_out, rxd_term_out, leds_out.tm_red}, 3'h5);
      panel_in <= 1'h0;
      far_u.leads(2'h3);
      step(3);
      check({lal_out, rl_req_out}, 2'h0);
      xfer(1'h1, `CTRL_OFF, 32'h1, rd);
      step(2);
      check({lal_out, rl_req_out}, 2'h3);
      far_u.leads(2'h0);
      xfer(1'h1, `CTRL_OFF, 32'h2, rd);
      xfer(1'h0, `CTRL_OFF, 32'h0, rd);
      check(rd, 32'h2);
      far_u.drive(7'h5C);
      step(3);
      check({lal_out, rxd_term_out, txd_line_out}, 3'h7);
      xfer(1'h1, `CTRL_OFF, 32'h0, rd);
      step(3);
      check({lal_out, rxd_term_out, txd_line_out}, 3'h1);
      xfer(1'h1, 8'h20, 32'hFFFFFFFF, rd);
      xfer(1'h0, 8'h20, 32'h0, rd);
      check(rd, 32'h0);
      $display("loop done");
   endtask

   // Prints the counts and the verdict, then stops the run.
   task automatic end_of_test;
      $display("checks %0d, mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Reset for three cycles, then the scenarios in turn.
   initial begin
      ref_clk_in = 1'h0;
      resetn_in = 1'h0;
      hsel_in = 1'h0;
      hwrite_in = 1'h0;
      htrans_in = 2'h0;
      hsize_in = 3'h2;
      haddr_in = 32'h0;
      hwdata_in = 32'h0;
      pattern_test_in = 1'h0;
      other_test_in = 1'h0;
      panel_in = 1'h0;
      step(2);
      check({hreadyout_out, rxd_term_out, txd_line_out, lal_out}, 4'hE);
      check(leds_out, 11'h000);
      step(1);
      resetn_in <= 1'h1;
      t_lamps();
      t_errors();
      t_pattern();
      t_loop();
      end_of_test();
   end
endmodule
